//--- core/pol_device.sv
// Notes on behaviour
// - target moves in fixed 12.5mV steps
// - step time divides manager master clock
// - voltage thresholds track setpoint percentages
// - non-latching trip retries every 130ms
// - latching trip restarts only after release
// - warnings never shut converter down
// - above 120C temp flag goes low
// - temp warning withdrawn below 117C
// - power good window 110% / 90-95%
// - power good held low outside steady
// - power good warning drives flag, notify
// - external low on line is warning
// - any fault shuts converter down
// - overcurrent below undervoltage: fast off
// - overcurrent temperature compensation selectable
// - undervoltage in steady: ramped shutdown
// - protections latching or non-latching, undervoltage also disabled
// - all flags in one status register
// - manager polls status continuously
// - software keeps start-up below overcurrent
// - hiccup timed from zero output
`timescale 1ns/10ps
module pol_device
    import pol_pkg::*;
#(
    parameter int HICCUP_CNT = HICCUP_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // link to the power manager
    pol_link_if.device link,
    // measurements, voltages as codes in 12.5mV steps, temperature in degrees C
    input wire logic [9:0] vMeas,
    input wire logic [9:0] preBias,
    input wire logic signed [7:0] tempC,
    input wire logic ocLimitHit,
    // power stage
    output logic [9:0] vTarget,
    output logic highSideOn,
    output logic lowSideOn,
    output logic [6:0] ocThresh,
    output logic tempCompEn
);
    function automatic logic [9:0] pctOf(logic [7:0] v, logic [7:0] p);
        logic [15:0] prod;
        prod = 16'(v) * 16'(p);
        return 10'(prod / 16'(PCT_FULL));
    endfunction : pctOf

    // ==========================================
    // register file
    logic [7:0] protType_q, protType_d, thresh_q, thresh_d;
    logic [7:0] report_q, report_d, ramp_q, ramp_d;
    logic [7:0] setpt_q, setpt_d, curLim_q, curLim_d;
    logic run_q, run_d, ocFlag_q, ocFlag_d, uvFlag_q, uvFlag_d;
    logic twActive_q, twActive_d, pgFlag_q, pgFlag_d;
    logic notify_q, notify_d, ready_q, ready_d;
    logic [7:0] rdata_q, rdata_d;
    logic [9:0] pgHi_q, pgHi_d, pgLo_q, pgLo_d, uvThr_q, uvThr_d;
    logic [7:0] statusVal;
    // control
    pol_state_t state_q, state_d;
    logic [9:0] vTarget_q, vTarget_d;
    logic [3:0] stepCnt_q, stepCnt_d;
    logic [23:0] hicCnt_q, hicCnt_d;
    logic tripped_q, tripped_d, latchTrip_q, latchTrip_d;
    logic ocArmed_q, ocArmed_d, runCycled_q, runCycled_d;
    logic running, atLevel, inWindow, pgWarn, ocFault, uvFault;
    logic accept, goingUp, stepNow;
    logic [3:0] stepDiv;

    assign accept = link.regValid && !ready_q;
    assign running = state_q == RAMP_UP || state_q == STEADY;
    assign atLevel = state_q == STEADY && vTarget_q == 10'(setpt_q);
    assign inWindow = vMeas <= pgHi_q && vMeas >= pgLo_q;
    assign pgWarn = atLevel && (!inWindow || !link.pgLevel);
    assign ocFault = running && ocArmed_q && ocLimitHit && vMeas < uvThr_q;
    assign uvFault = atLevel && !protType_q[PT_UV_DIS] && vMeas < uvThr_q
        && !ocFault;
    assign statusVal = {4'h0, uvFlag_q, ocFlag_q, pgFlag_q, !twActive_q};

    always_comb
    begin
        protType_d = protType_q;
        thresh_d = thresh_q;
        report_d = report_q;
        ramp_d = ramp_q;
        setpt_d = setpt_q;
        curLim_d = curLim_q;
        run_d = run_q;
        ocFlag_d = ocFlag_q;
        uvFlag_d = uvFlag_q;
        rdata_d = rdata_q;
        ready_d = accept;
        if (accept && link.regWrite)
        begin
            unique case (link.regAddr)
                PROT_TYPE_OFS: protType_d = link.regWdata;
                THRESH_OFS: thresh_d = link.regWdata;
                REPORT_OFS: report_d = link.regWdata;
                RAMP_OFS: ramp_d = link.regWdata;
                SETPOINT_OFS: setpt_d = link.regWdata;
                CUR_LIMIT_OFS: curLim_d = link.regWdata;
                RUN_OFS: run_d = link.regWdata[0];
                STATUS_OFS:
                begin
                    ocFlag_d = ocFlag_q | link.regWdata[ST_OC];
                    uvFlag_d = uvFlag_q | link.regWdata[ST_UV];
                end
                default: ;
            endcase
        end
        if (accept && !link.regWrite)
        begin
            unique case (link.regAddr)
                PROT_TYPE_OFS: rdata_d = protType_q;
                THRESH_OFS: rdata_d = thresh_q;
                REPORT_OFS: rdata_d = report_q;
                RAMP_OFS: rdata_d = ramp_q;
                SETPOINT_OFS: rdata_d = setpt_q;
                CUR_LIMIT_OFS: rdata_d = curLim_q;
                RUN_OFS: rdata_d = {7'h0, run_q};
                STATUS_OFS: rdata_d = statusVal;
                default: rdata_d = 8'h00;
            endcase
        end
        // fault clears its flag, beats restore
        if (ocFault)
            ocFlag_d = 1'b0;
        if (uvFault)
            uvFlag_d = 1'b0;
        twActive_d = twActive_q;
        if (tempC > TEMP_WARN_ON_C)
            twActive_d = 1'b1;
        else if (tempC < TEMP_WARN_OFF_C)
            twActive_d = 1'b0;
        pgFlag_d = !pgWarn;
        notify_d = (report_q[RP_TEMP] && twActive_q)
            || (report_q[RP_PG] && pgWarn);
        pgHi_d = pctOf(setpt_q, PG_HIGH_PCT);
        pgLo_d = pctOf(setpt_q, thresh_q[TH_PG_NARROW] ?
            PG_LOW_PCT_NARROW : PG_LOW_PCT_WIDE);
        uvThr_d = pctOf(setpt_q, {1'b0, thresh_q[7:1]});
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            protType_q <= PROT_TYPE_RST;
            thresh_q <= THRESH_RST;
            report_q <= REPORT_RST;
            ramp_q <= RAMP_RST;
            setpt_q <= SETPOINT_RST;
            curLim_q <= CUR_LIMIT_RST;
            run_q <= 1'b0;
            ocFlag_q <= 1'b1;
            uvFlag_q <= 1'b1;
            twActive_q <= 1'b0;
            pgFlag_q <= 1'b1;
            notify_q <= 1'b0;
            ready_q <= 1'b0;
            rdata_q <= 8'h00;
            pgHi_q <= 10'h000;
            pgLo_q <= 10'h000;
            uvThr_q <= 10'h000;
        end
        else
        begin
            protType_q <= protType_d;
            thresh_q <= thresh_d;
            report_q <= report_d;
            ramp_q <= ramp_d;
            setpt_q <= setpt_d;
            curLim_q <= curLim_d;
            run_q <= run_d;
            ocFlag_q <= ocFlag_d;
            uvFlag_q <= uvFlag_d;
            twActive_q <= twActive_d;
            pgFlag_q <= pgFlag_d;
            notify_q <= notify_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            pgHi_q <= pgHi_d;
            pgLo_q <= pgLo_d;
            uvThr_q <= uvThr_d;
        end
    end

    // ==========================================
    // ramp and protection sequencer
    assign goingUp = state_q == RAMP_UP
        || (state_q == STEADY && vTarget_q < 10'(setpt_q));
    assign stepDiv = goingUp ? ramp_q[3:0] : ramp_q[7:4];
    // step held for (div+1) master ticks
    assign stepNow = link.masterTick && stepCnt_q == 4'h0;

    always_comb
    begin
        state_d = state_q;
        vTarget_d = vTarget_q;
        stepCnt_d = stepCnt_q;
        hicCnt_d = hicCnt_q;
        tripped_d = tripped_q;
        latchTrip_d = latchTrip_q;
        ocArmed_d = ocArmed_q;
        runCycled_d = runCycled_q;
        if (link.masterTick)
            stepCnt_d = stepNow ? stepDiv : stepCnt_q - 4'h1;
        if (running && vMeas > preBias)
            ocArmed_d = 1'b1;
        unique case (state_q)
            PWR_OFF:
            begin
                ocArmed_d = 1'b0;
                if (run_q)
                begin
                    state_d = RAMP_UP;
                    stepCnt_d = ramp_q[3:0];
                end
            end
            RAMP_UP, STEADY:
            begin
                if (ocFault)
                begin
                    vTarget_d = 10'h000;
                    ocArmed_d = 1'b0;
                    tripped_d = 1'b0;
                    state_d = protType_q[PT_OC_LATCH] ? LATCHED : HICCUP;
                    runCycled_d = 1'b0;
                    hicCnt_d = 24'(HICCUP_CNT - 1);
                end
                else if (uvFault || !run_q)
                begin
                    tripped_d = uvFault;
                    latchTrip_d = protType_q[PT_UV_LATCH];
                    state_d = RAMP_DOWN;
                    stepCnt_d = ramp_q[7:4];
                end
                else if (vTarget_q == 10'(setpt_q))
                    state_d = STEADY;
                else if (stepNow)
                    vTarget_d = goingUp ? vTarget_q + 10'h001
                        : vTarget_q - 10'h001;
            end
            RAMP_DOWN:
            begin
                if (vTarget_q == 10'h000)
                begin
                    ocArmed_d = 1'b0;
                    runCycled_d = 1'b0;
                    hicCnt_d = 24'(HICCUP_CNT - 1);
                    if (!tripped_q)
                        state_d = PWR_OFF;
                    else
                        state_d = latchTrip_q ? LATCHED : HICCUP;
                    tripped_d = 1'b0;
                end
                else if (stepNow)
                    vTarget_d = vTarget_q - 10'h001;
            end
            HICCUP:
            begin
                // retry after hiccup if still on
                if (hicCnt_q == 24'h0)
                begin
                    state_d = run_q ? RAMP_UP : PWR_OFF;
                    stepCnt_d = ramp_q[3:0];
                end
                else
                    hicCnt_d = hicCnt_q - 24'h1;
            end
            LATCHED:
            begin
                if (!run_q)
                    runCycled_d = 1'b1;
                if (hicCnt_q != 24'h0)
                    hicCnt_d = hicCnt_q - 24'h1;
                // released by flag restore or on cycling
                else if (run_q && !ocLimitHit
                    && (runCycled_q || (ocFlag_q && uvFlag_q)))
                begin
                    state_d = RAMP_UP;
                    stepCnt_d = ramp_q[3:0];
                end
            end
            default:
                state_d = PWR_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= PWR_OFF;
            vTarget_q <= 10'h000;
            stepCnt_q <= 4'h0;
            hicCnt_q <= 24'h0;
            tripped_q <= 1'b0;
            latchTrip_q <= 1'b0;
            ocArmed_q <= 1'b0;
            runCycled_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            vTarget_q <= vTarget_d;
            stepCnt_q <= stepCnt_d;
            hicCnt_q <= hicCnt_d;
            tripped_q <= tripped_d;
            latchTrip_q <= latchTrip_d;
            ocArmed_q <= ocArmed_d;
            runCycled_q <= runCycled_d;
        end
    end

    // ==========================================
    // outputs
    assign vTarget = vTarget_q;
    assign highSideOn = running || state_q == RAMP_DOWN;
    assign lowSideOn = highSideOn;
    assign ocThresh = curLim_q[7:1];
    // compensation switch from current limit word
    assign tempCompEn = curLim_q[CL_TCOMP];
    assign link.regRdata = rdata_q;
    assign link.regReady = ready_q;
    assign link.notify = notify_q;
    assign link.pgOe = !(atLevel && inWindow);
endmodule : pol_device

//--- core/pol_pkg.sv
package pol_pkg;
    // ==========================================
    // timing
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int HICCUP_MS = 130;
    localparam int HICCUP_CYCLES = HICCUP_MS * (REF_CLK_HZ / 1000);
    localparam int MASTER_DIV = 100;
    // ==========================================
    // limits, percentages of setpoint and degrees C
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] PG_HIGH_PCT = 8'h6e;
    localparam logic [7:0] PG_LOW_PCT_WIDE = 8'h5a;
    localparam logic [7:0] PG_LOW_PCT_NARROW = 8'h5f;
    localparam logic signed [7:0] TEMP_WARN_ON_C = 8'sh78;
    localparam logic signed [7:0] TEMP_WARN_OFF_C = 8'sh75;
    // ==========================================
    // device register offsets
    localparam logic [7:0] PROT_TYPE_OFS = 8'h00;
    localparam logic [7:0] THRESH_OFS = 8'h01;
    localparam logic [7:0] REPORT_OFS = 8'h02;
    localparam logic [7:0] RAMP_OFS = 8'h03;
    localparam logic [7:0] SETPOINT_OFS = 8'h07;
    localparam logic [7:0] CUR_LIMIT_OFS = 8'h08;
    localparam logic [7:0] RUN_OFS = 8'h15;
    localparam logic [7:0] STATUS_OFS = 8'h16;
    // ==========================================
    // device fields
    localparam int PT_OC_LATCH = 0;
    localparam int PT_UV_LATCH = 1;
    localparam int PT_UV_DIS = 2;
    localparam int TH_PG_NARROW = 0;
    localparam int RP_TEMP = 0;
    localparam int RP_PG = 1;
    localparam int CL_TCOMP = 0;
    localparam int ST_TEMP = 0;
    localparam int ST_PG = 1;
    localparam int ST_OC = 2;
    localparam int ST_UV = 3;
    // ==========================================
    // device reset values
    localparam logic [7:0] PROT_TYPE_RST = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'h96;
    localparam logic [7:0] REPORT_RST = 8'h03;
    localparam logic [7:0] RAMP_RST = 8'h33;
    localparam logic [7:0] SETPOINT_RST = 8'h50;
    localparam logic [7:0] CUR_LIMIT_RST = 8'h81;
    // ==========================================
    // manager registers on the ahb side
    localparam logic [7:0] MGR_CMD_OFS = 8'h00;
    localparam logic [7:0] MGR_STATUS_OFS = 8'h04;
    localparam logic [7:0] MGR_POLL_OFS = 8'h08;
    localparam int CMD_WRITE = 16;
    // ==========================================
    // states
    typedef enum logic [2:0] {
        PWR_OFF = 3'h0,
        RAMP_UP = 3'h1,
        STEADY = 3'h3,
        RAMP_DOWN = 3'h2,
        HICCUP = 3'h6,
        LATCHED = 3'h7
    } pol_state_t;
    typedef enum logic [1:0] {
        LINK_IDLE = 2'h0,
        LINK_CMD = 2'h1,
        LINK_POLL = 2'h3
    } link_state_t;
endpackage : pol_pkg

//--- core/pol_link_if.sv
`timescale 1ns/10ps
interface pol_link_if;
    logic masterTick;
    logic regValid;
    logic regWrite;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic regReady;
    logic notify;
    logic pgOe;
    logic extPgLow;
    logic pgLevel;

    // open-drain power good line, pulled up
    assign pgLevel = !(pgOe || extPgLow);

    modport device (
        input masterTick, regValid, regWrite, regAddr, regWdata, pgLevel,
        output regRdata, regReady, notify, pgOe
    );
    modport manager (
        output masterTick, regValid, regWrite, regAddr, regWdata,
        input regRdata, regReady, notify, pgLevel
    );
endinterface : pol_link_if

//--- core/power_manager_end.sv
`timescale 1ns/10ps
module power_manager_end
    import pol_pkg::*;
#(
    parameter int DIV = MASTER_DIV
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // link to the converter
    pol_link_if.manager link
);
    // ==========================================
    // master clock divider
    logic [15:0] divCnt_q, divCnt_d;
    logic tick_q, tick_d;
    // ==========================================
    // bus side and link engine
    link_state_t lst_q, lst_d;
    logic wrPend_q, wrPend_d;
    logic [7:0] dAddr_q, dAddr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [16:0] cmd_q, cmd_d;
    logic cmdPend_q, cmdPend_d, pollEn_q, pollEn_d;
    logic [7:0] lastRd_q, lastRd_d, polled_q, polled_d;
    logic [31:0] statusWord;
    logic addrPhase;

    assign addrPhase = hsel && hready && htrans[1];
    assign statusWord = {polled_q, 6'h0, link.pgLevel, link.notify,
        lastRd_q, 7'h0, lst_q != LINK_IDLE || cmdPend_q};

    always_comb
    begin
        divCnt_d = divCnt_q - 16'h1;
        tick_d = 1'b0;
        if (divCnt_q == 16'h0)
        begin
            divCnt_d = 16'(DIV - 1);
            tick_d = 1'b1;
        end
        wrPend_d = addrPhase && hwrite;
        dAddr_d = addrPhase ? haddr[7:0] : dAddr_q;
        hrdata_d = hrdata_q;
        if (addrPhase && !hwrite)
        begin
            unique case (haddr[7:0])
                MGR_CMD_OFS: hrdata_d = {15'h0, cmd_q};
                MGR_STATUS_OFS: hrdata_d = statusWord;
                MGR_POLL_OFS: hrdata_d = {31'h0, pollEn_q};
                default: hrdata_d = 32'h0;
            endcase
        end
        cmd_d = cmd_q;
        cmdPend_d = cmdPend_q;
        pollEn_d = pollEn_q;
        // a command written while one is pending or in progress is dropped
        if (wrPend_q && dAddr_q == MGR_CMD_OFS && !cmdPend_q
            && lst_q != LINK_CMD)
        begin
            cmd_d = hwdata[16:0];
            cmdPend_d = 1'b1;
        end
        if (wrPend_q && dAddr_q == MGR_POLL_OFS)
            pollEn_d = hwdata[0];
        lst_d = lst_q;
        lastRd_d = lastRd_q;
        polled_d = polled_q;
        unique case (lst_q)
            LINK_IDLE:
                if (cmdPend_q)
                begin
                    lst_d = LINK_CMD;
                    cmdPend_d = 1'b0;
                end
                else if (pollEn_q)
                    lst_d = LINK_POLL;
            LINK_CMD:
                if (link.regReady)
                begin
                    lastRd_d = link.regRdata;
                    lst_d = LINK_IDLE;
                end
            LINK_POLL:
                if (link.regReady)
                begin
                    polled_d = link.regRdata;
                    lst_d = LINK_IDLE;
                end
            default:
                lst_d = LINK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_q <= 16'h0;
            tick_q <= 1'b0;
            lst_q <= LINK_IDLE;
            wrPend_q <= 1'b0;
            dAddr_q <= 8'h00;
            hrdata_q <= 32'h0;
            cmd_q <= 17'h0;
            cmdPend_q <= 1'b0;
            pollEn_q <= 1'b0;
            lastRd_q <= 8'h00;
            polled_q <= 8'h00;
        end
        else
        begin
            divCnt_q <= divCnt_d;
            tick_q <= tick_d;
            lst_q <= lst_d;
            wrPend_q <= wrPend_d;
            dAddr_q <= dAddr_d;
            hrdata_q <= hrdata_d;
            cmd_q <= cmd_d;
            cmdPend_q <= cmdPend_d;
            pollEn_q <= pollEn_d;
            lastRd_q <= lastRd_d;
            polled_q <= polled_d;
        end
    end

    // ==========================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    // one shared master tick for all converters
    assign link.masterTick = tick_q;
    assign link.regValid = lst_q != LINK_IDLE;
    assign link.regWrite = lst_q == LINK_CMD && cmd_q[CMD_WRITE];
    assign link.regAddr = lst_q == LINK_POLL ? STATUS_OFS : cmd_q[7:0];
    // zero outside a command so a later command word cannot move it
    assign link.regWdata = lst_q == LINK_CMD ? cmd_q[15:8] : 8'h00;
endmodule : power_manager_end

//--- testbench/pol_link_monitor.sv
`timescale 1ns/10ps
// ====
// link checker
module pol_link_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // link signals
    input wire logic masterTick,
    input wire logic regValid,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regReady,
    input wire logic notify,
    input wire logic pgOe,
    input wire logic extPgLow
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_wait;
        regValid && !regReady;
    endsequence
    sequence s_ans;
        regValid && regReady;
    endsequence
    a_link_walk: assert property (
        $rose(regValid) |-> s_wait ##1 s_ans ##1 !regValid)
        else $error("link walk broken");
    a_ready_pulse: assert property (
        regReady |=> !regReady)
        else $error("ready too long");
    a_ready_drop: assert property (
        regReady |=> !regValid)
        else $error("valid held after ready");
    a_ready_cause: assert property (
        regReady |-> $past(regValid))
        else $error("ready without request");
    a_req_stable: assert property (
        s_wait |=> $stable(regAddr) && $stable(regWrite)
            && $stable(regWdata))
        else $error("request moved");
    // divider of 4 as built by the bench
    a_tick_period: assert property (
        masterTick |=> !masterTick [*3] ##1 masterTick)
        else $error("tick period wrong");
    a_unmapped_zero: assert property (
        s_wait and !regWrite && regAddr == 8'h40 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_ext_pg: assert property (
        $rose(extPgLow) && !pgOe |-> ##[1:4] notify)
        else $error("external pull not reported");
endmodule : pol_link_monitor

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench
    import pol_pkg::*;
;
    // ====
    // stimulus and wires
    logic ref_clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic ocHit = 1'h0, follow = 1'h1, hiOn, loOn, tcEn, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [6:0] ocTh;
    // pg probes: in and just out at each edge of the window
    logic [9:0] pgLv [6] = '{10'h2c, 10'h2d, 10'h24, 10'h23, 10'h26, 10'h25};
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [9:0] vMeas = 10'h0, vForce = 10'h0, prevT = 10'h0, fromT, vTarget;
    logic signed [7:0] tempC = 8'sh19;
    logic hready;
    int err_count = 0, checks = 0, cyc = 0, zeroAt, riseAt, gap;
    pol_link_if link();
    pol_device #(.HICCUP_CNT(50)) pol_device_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .link(link.device), .vMeas(vMeas),
        .preBias(10'h0), .tempC(tempC), .ocLimitHit(ocHit),
        .vTarget(vTarget), .highSideOn(hiOn), .lowSideOn(loOn),
        .ocThresh(ocTh), .tempCompEn(tcEn));
    power_manager_end #(.DIV(4)) power_manager_end_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .link(link.manager));
    pol_link_monitor pol_link_monitor_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .masterTick(link.masterTick),
        .regValid(link.regValid), .regWrite(link.regWrite),
        .regAddr(link.regAddr), .regWdata(link.regWdata),
        .regRdata(link.regRdata), .regReady(link.regReady),
        .notify(link.notify), .pgOe(link.pgOe), .extPgLow(link.extPgLow));
    always #5 ref_clk = ~ref_clk;
    // plant: output follows target unless a fault level is forced
    always @(posedge ref_clk) vMeas <= follow ? vTarget : vForce;
    // ====
    // tasks
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : check
    task summarize;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask : ahb
    // device access through the manager; leaves its status word in rd
    task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        ahb(1'h1, MGR_CMD_OFS, {15'h0, w, d, a});
        repeat (40)
        begin
            ahb(1'h0, MGR_STATUS_OFS, 32'h0);
            if (rd[0] === 1'h0) break;
        end
    endtask : dev
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        dev(1'h0, a, 8'h0);
        check("dev reg", e, rd[15:8]);
    endtask : rdchk
    task waitT(input logic [9:0] v);
        for (int n = 0; n < 2000 && vTarget !== v; n++) @(posedge ref_clk);
    endtask : waitT
    // ====
    // ramp watcher
    // mid-cycle, so gap is settled before any wait returns
    always @(negedge ref_clk)
    begin
        cyc = cyc + 1;
        if (reset_n && vTarget !== prevT)
        begin
            check("step", 1'h1, 10'(vTarget - prevT) == 10'h1
                || 10'(prevT - vTarget) == 10'h1 || vTarget == 10'h0);
            gap = cyc - riseAt;
            riseAt = cyc;
            if (vTarget == 10'h0) zeroAt = cyc;
            fromT = prevT;
            prevT = vTarget;
        end
    end
    // ====
    // tests
    initial
    begin
        int i;
        link.extPgLow = 1'h0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'h1;
        @(posedge ref_clk);
        rdchk(PROT_TYPE_OFS, PROT_TYPE_RST);
        rdchk(THRESH_OFS, THRESH_RST);
        rdchk(REPORT_OFS, REPORT_RST);
        rdchk(RAMP_OFS, RAMP_RST);
        rdchk(8'h40, 8'h0);
        check("comp", 1'h1, tcEn);
        check("oc thr", CUR_LIMIT_RST[7:1], ocTh);
        dev(1'h1, CUR_LIMIT_OFS, 8'h80);
        check("comp", 1'h0, tcEn);
        dev(1'h1, SETPOINT_OFS, 8'h28);
        dev(1'h1, RAMP_OFS, 8'h10);
        dev(1'h1, RUN_OFS, 8'h1);
        waitT(10'h28);
        check("rise gap", 4, gap);
        follow <= 1'h0;
        vForce <= 10'h28;
        for (i = 0; i < 6; i++)
        begin
            if (i == 4) dev(1'h1, THRESH_OFS, 8'h97);
            vForce <= pgLv[i];
            repeat (6) @(posedge ref_clk);
            check("pg", !i[0], link.pgLevel);
            check("pg notify", i[0], link.notify);
            check("on", 1'h1, hiOn);
        end
        vForce <= 10'h28;
        repeat (6) @(posedge ref_clk);
        link.extPgLow <= 1'h1;
        repeat (6) @(posedge ref_clk);
        dev(1'h0, STATUS_OFS, 8'h0);
        check("pg flag", 1'h0, rd[9]);
        link.extPgLow <= 1'h0;
        for (i = 0; i < 3; i++)
        begin
            tempC <= 8'sh79 - 8'(i * 3) - 8'(i / 2);
            repeat (6) @(posedge ref_clk);
            dev(1'h0, STATUS_OFS, 8'h0);
            check("temp ok", i == 2, rd[8]);
            check("temp notify", i != 2, link.notify);
        end
        dev(1'h1, REPORT_OFS, 8'h02);
        tempC <= 8'sh79;
        repeat (6) @(posedge ref_clk);
        check("quiet", 1'h0, link.notify);
        tempC <= 8'sh19;
        vForce <= 10'h14;
        waitT(10'h0);
        check("fall gap", 8, gap);
        dev(1'h0, STATUS_OFS, 8'h0);
        check("uv flag", 1'h0, rd[11]);
        follow <= 1'h1;
        waitT(10'h1);
        check("hiccup", 1'h1, gap >= 50 && gap <= 62);
        check("pg ramp", 1'h0, link.pgLevel);
        waitT(10'h28);
        dev(1'h1, PROT_TYPE_OFS, 8'h01);
        ocHit <= 1'h1;
        follow <= 1'h0;
        waitT(10'h0);
        check("fast off", 10'h28, fromT);
        check("switches", 2'h0, {hiOn, loOn});
        ocHit <= 1'h0;
        follow <= 1'h1;
        repeat (150) @(posedge ref_clk);
        check("latched", 10'h0, vTarget);
        dev(1'h1, STATUS_OFS, 8'h0c);
        waitT(10'h1);
        check("restart", 10'h1, vTarget);
        ahb(1'h1, MGR_POLL_OFS, 32'h1);
        repeat (8) @(posedge ref_clk);
        ahb(1'h0, MGR_STATUS_OFS, 32'h0);
        check("polled", 8'h0f, rd[31:24]);
        check("resp", 1'h0, hresp);
        summarize();
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        summarize();
    end
endmodule : testbench
